// file: hw/acs_defines.svh
// offsets, field positions and timing counts of the conversion sequencer
// assumes the includer uses byte addresses on a 12-bit register address port
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// register offsets
`define ACS_OFS_STS 12'h000
`define ACS_OFS_IEN 12'h004
`define ACS_OFS_CTRL 12'h008
`define ACS_OFS_CFG1 12'h00C
`define ACS_OFS_CHSEL 12'h028
`define ACS_OFS_DATA 12'h040
`define ACS_OFS_CCFG 12'h308

// status and interrupt enable bits
`define ACS_B_EOC 2
`define ACS_B_EOS 3
`define ACS_B_OVR 4

// control bits
`define ACS_B_ON 0
`define ACS_B_GO 2
`define ACS_B_STOP 4
`define ACS_B_CAL 31

// config_register_one fields
`define ACS_B_RES 3
`define ACS_B_ALIGN 5
`define ACS_B_TSEL 6
`define ACS_B_EDGE 10
`define ACS_B_REPEAT 13
`define ACS_B_STEP 16

// common_config_register
`define ACS_B_TEMP_SENSOR_ON 23

// channels
`define ACS_NUM_CH 18
`define ACS_CH_TEMP 5'h10
`define ACS_CH_VREF 5'h11

// times in tenths of a converter clock cycle
`define ACS_TSMPL_X10 15
`define ACS_TSAR12_X10 125
`define ACS_TSAR10_X10 115
`define ACS_TSAR8_X10 95
`define ACS_TSAR6_X10 75
// cycle counts derived from the times, and the calibration cycle count
`define ACS_SMPL_CYC ((`ACS_TSMPL_X10 + 9) / 10)
`define ACS_SAR_CYC(t) (((t) + `ACS_TSMPL_X10) / 10 - `ACS_SMPL_CYC)
`define ACS_CAL_CYC 83

`endif

// file: hw/acs_pkg.sv
// types of the conversion sequencer
// assumes acs_defines.svh for field positions
package acs_pkg;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_CAL = 4'b0010,
      ST_SAMPLE = 4'b0100,
      ST_CONVERT = 4'b1000
   } acs_state_e;

   typedef struct packed
   {
      acs_state_e st;
      logic [7:0] cnt;
      logic [4:0] chan;
      logic [4:0] seq_pos;
      logic conv_on;
      logic go;
      logic [2:0] ien;
      logic eoc;
      logic eos;
      logic ovr;
      logic [2:0] tsel;
      logic [1:0] edge_sel;
      logic align;
      logic [1:0] res;
      logic repeat_mode;
      logic step;
      logic [17:0] chmask;
      logic temp_sensor_on;
      logic [15:0] data;
      logic [31:0] rdata;
      logic [11:0] sar_s1;
      logic [11:0] sar_s2;
      logic [6:0] calf_s1;
      logic [6:0] calf_s2;
      logic irq;
   } acs_seq_s;

   typedef struct packed
   {
      logic [5:0] s1;
      logic [5:0] s2;
      logic prev;
      logic pulse;
   } acs_trig_s;

endpackage

// file: hw/acs_trigger_detect.sv
// trigger source selection and edge detection
// assumes trigger inputs are asynchronous to REF_CLK_I
`timescale 1ns/1ns
module acs_trigger_detect
   import acs_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // trigger sources
   input wire logic [4:0] timer_trigger_in_i,
   input wire logic ext_trig_i,
   // configuration
   input wire logic [2:0] trigger_source_select_i,
   input wire logic [1:0] trigger_edge_select_i,
   // detected event
   output logic trig_o
);

   acs_trig_s q, d;
   logic sel;

   always_comb
   begin
      d = q;
      d.s1 = {ext_trig_i, timer_trigger_in_i};
      d.s2 = q.s1;
      // codes 101 and 110 select nothing
      unique case (trigger_source_select_i)
         3'h7: sel = q.s2[5];
         3'h5, 3'h6: sel = 1'b0;
         default: sel = q.s2[trigger_source_select_i];
      endcase
      d.prev = sel;
      unique case (trigger_edge_select_i)
         2'h1: d.pulse = sel & ~q.prev;
         2'h2: d.pulse = ~sel & q.prev;
         2'h3: d.pulse = sel ^ q.prev;
         default: d.pulse = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         q <= '0;
      else
         q <= d;
   end

   assign trig_o = q.pulse;

endmodule

// file: hw/acs_sequencer.sv
// conversion sequencer: calibration, channel sequencing, triggers, results, flags
// assumes the analog core holds SAR_RESULT_I and CAL_FACTOR_I steady at phase ends
`timescale 1ns/1ns
`include "acs_defines.svh"
// Operation
// - software sets calibration start; device clears it when calibration ends.
// - calibration factor appears in result bits 6 to 0.
// - no conversion starts or runs while calibration is in progress.
// - repeat mode off converts channel or group once per start.
// - conversion starts by software go bit or selected hardware trigger.
// - repeat mode on converts channel or group again and again; step mode still returns to idle after one channel.
// - each conversion stores result, sets done flag, interrupt if enabled.
// - last channel sets sequence done flag, interrupt if enabled.
// - step mode converts only the next single channel per trigger.
// - step mode off converts every channel of sequence per trigger.
// - sixteen external channels numbered 0 to 15 are selectable.
// - temperature sensor is channel 16, enabled by common config bit.
// - internal reference voltage is channel 17.
// - three-bit source field: timers 000 to 100, 111 external pin.
// - edge field: 00 off, 01 rising, 10 falling, 11 both.
// - alignment bit stores result left or right in sixteen bits.
// - resolution 12/10/8/6 bits, 12.5/11.5/9.5/7.5 cycles after 1.5 sampling.
// - conversion completing while done flag set sets overrun flag.
module acs_sequencer
   import acs_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   // register port
   input wire logic [11:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // trigger sources
   input wire logic [4:0] TIMER_TRIGGER_IN_I,
   input wire logic EXT_TRIG_I,
   // analog core
   input wire logic [11:0] SAR_RESULT_I,
   input wire logic [6:0] CAL_FACTOR_I,
   output logic [4:0] CHANNEL_SELECT_O,
   output logic SAMPLE_O,
   output logic CONVERT_O,
   output logic CALIBRATE_O,
   output logic TEMP_SENSOR_ON_O,
   // interrupt
   output logic IRQ_O
);

   acs_seq_s q, d;
   logic trig;
   logic fin;
   logic last;
   logic ctl_wr;
   logic [5:0] nx_first;
   logic [5:0] nx_after;

   // lowest selected channel at or above from, with found bit
   function automatic logic [5:0] next_chan(input logic [17:0] mask, input logic [5:0] from);
      logic [5:0] r;
      r = '0;
      for (int i = `ACS_NUM_CH - 1; i >= 0; i--)
      begin
         if (mask[i] && (6'(i) >= from))
            r = {1'b1, 5'(i)};
      end
      return r;
   endfunction

   // approximation cycles for the selected resolution
   function automatic logic [7:0] sar_cycles(input logic [1:0] res);
      logic [7:0] c;
      unique case (res)
         2'h0: c = 8'(`ACS_SAR_CYC(`ACS_TSAR12_X10));
         2'h1: c = 8'(`ACS_SAR_CYC(`ACS_TSAR10_X10));
         2'h2: c = 8'(`ACS_SAR_CYC(`ACS_TSAR8_X10));
         2'h3: c = 8'(`ACS_SAR_CYC(`ACS_TSAR6_X10));
      endcase
      return c;
   endfunction

   // keep top bits of the raw result, place left or right
   function automatic logic [15:0] align_result(input logic [11:0] v, input logic [1:0] res,
                                                input logic left);
      logic [3:0] sh;
      logic [15:0] t;
      sh = 4'h4 + {1'b0, res, 1'b0};
      t = {v, 4'h0} >> sh;
      return left ? (t << sh) : t;
   endfunction

   acs_trigger_detect u_trig
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .timer_trigger_in_i(TIMER_TRIGGER_IN_I),
      .ext_trig_i(EXT_TRIG_I),
      .trigger_source_select_i(q.tsel),
      .trigger_edge_select_i(q.edge_sel),
      .trig_o(trig)
   );

   always_comb
   begin
      logic wr_ctrl;
      logic sw_go;
      logic start;
      logic [5:0] nx;
      wr_ctrl = 1'b0;
      sw_go = 1'b0;
      start = 1'b0;
      nx = '0;
      d = q;
      d.rdata = '0;
      d.sar_s1 = SAR_RESULT_I;
      d.sar_s2 = q.sar_s1;
      d.calf_s1 = CAL_FACTOR_I;
      d.calf_s2 = q.calf_s1;
      // register writes; flag clears come before any hardware set
      if (WR_I)
      begin
         case (ADDR_I)
            `ACS_OFS_STS:
            begin
               if (WDATA_I[`ACS_B_EOC]) d.eoc = 1'b0;
               if (WDATA_I[`ACS_B_EOS]) d.eos = 1'b0;
               if (WDATA_I[`ACS_B_OVR]) d.ovr = 1'b0;
            end
            `ACS_OFS_IEN: d.ien = WDATA_I[`ACS_B_OVR:`ACS_B_EOC];
            `ACS_OFS_CTRL: wr_ctrl = 1'b1;
            `ACS_OFS_CFG1:
            begin
               d.res = WDATA_I[`ACS_B_RES +: 2];
               d.align = WDATA_I[`ACS_B_ALIGN];
               d.tsel = WDATA_I[`ACS_B_TSEL +: 3];
               d.edge_sel = WDATA_I[`ACS_B_EDGE +: 2];
               d.repeat_mode = WDATA_I[`ACS_B_REPEAT];
               d.step = WDATA_I[`ACS_B_STEP];
            end
            `ACS_OFS_CHSEL: d.chmask = WDATA_I[`ACS_NUM_CH-1:0];
            `ACS_OFS_CCFG: d.temp_sensor_on = WDATA_I[`ACS_B_TEMP_SENSOR_ON];
            default: ;
         endcase
      end
      if (wr_ctrl)
      begin
         d.conv_on = WDATA_I[`ACS_B_ON];
         // calibration only from idle with the converter off
         if (WDATA_I[`ACS_B_CAL] && !q.conv_on && q.st == ST_IDLE)
         begin
            d.st = ST_CAL;
            d.cnt = '0;
         end
         sw_go = WDATA_I[`ACS_B_GO] && q.conv_on && q.st != ST_CAL && !q.go;
         if (sw_go)
            d.go = 1'b1;
      end
      // software start without edge detection, else armed trigger
      start = q.st == ST_IDLE && q.conv_on &&
              ((sw_go && q.edge_sel == 2'h0) || (q.go && q.edge_sel != 2'h0 && trig));
      unique case (q.st)
         ST_IDLE:
         begin
            if (start)
            begin
               nx = next_chan(q.chmask, q.step ? {1'b0, q.seq_pos} : 6'h00);
               if (nx[5])
               begin
                  d.chan = nx[4:0];
                  d.st = ST_SAMPLE;
                  d.cnt = '0;
               end
               else if (q.edge_sel == 2'h0)
                  d.go = 1'b0;
            end
         end
         ST_CAL:
         begin
            d.cnt = q.cnt + 8'h01;
            if (q.cnt == 8'(`ACS_CAL_CYC - 1))
            begin
               d.data = {9'h000, q.calf_s2};
               d.st = ST_IDLE;
            end
         end
         ST_SAMPLE:
         begin
            d.cnt = q.cnt + 8'h01;
            if (q.cnt == 8'(`ACS_SMPL_CYC - 1))
            begin
               d.st = ST_CONVERT;
               d.cnt = '0;
            end
         end
         ST_CONVERT:
         begin
            d.cnt = q.cnt + 8'h01;
            if (q.cnt == sar_cycles(q.res) - 8'h01)
            begin
               d.cnt = '0;
               d.data = align_result(q.sar_s2, q.res, q.align);
               d.eoc = 1'b1;
               if (q.eoc)
                  d.ovr = 1'b1;
               nx = next_chan(q.chmask, {1'b0, q.chan} + 6'h01);
               if (!nx[5])
                  d.eos = 1'b1;
               if (q.step)
               begin
                  d.seq_pos = nx[5] ? nx[4:0] : 5'h00;
                  d.st = ST_IDLE;
                  if (q.edge_sel == 2'h0)
                     d.go = 1'b0;
               end
               else if (nx[5])
                  d.chan = nx[4:0];
               else if (q.repeat_mode && q.go)
                  d.chan = nx_first[4:0];
               else
               begin
                  d.st = ST_IDLE;
                  if (q.edge_sel == 2'h0)
                     d.go = 1'b0;
               end
               if (d.st == ST_CONVERT)
                  d.st = ST_SAMPLE;
            end
         end
      endcase
      // stop request or converter off aborts conversion
      if (wr_ctrl && (WDATA_I[`ACS_B_STOP] || !WDATA_I[`ACS_B_ON]))
      begin
         d.go = 1'b0;
         if (q.st == ST_SAMPLE || q.st == ST_CONVERT)
            d.st = ST_IDLE;
      end
      if (RD_I)
      begin
         case (ADDR_I)
            `ACS_OFS_STS: d.rdata = 32'({q.ovr, q.eos, q.eoc}) << `ACS_B_EOC;
            `ACS_OFS_IEN: d.rdata = 32'(q.ien) << `ACS_B_EOC;
            `ACS_OFS_CTRL: d.rdata = (32'(q.st == ST_CAL) << `ACS_B_CAL) |
                                     (32'(q.go) << `ACS_B_GO) | 32'(q.conv_on);
            `ACS_OFS_CFG1: d.rdata = (32'(q.res) << `ACS_B_RES) |
                                     (32'(q.align) << `ACS_B_ALIGN) |
                                     (32'(q.tsel) << `ACS_B_TSEL) |
                                     (32'(q.edge_sel) << `ACS_B_EDGE) |
                                     (32'(q.repeat_mode) << `ACS_B_REPEAT) |
                                     (32'(q.step) << `ACS_B_STEP);
            `ACS_OFS_CHSEL: d.rdata = 32'(q.chmask);
            `ACS_OFS_DATA: d.rdata = 32'(q.data);
            `ACS_OFS_CCFG: d.rdata = 32'(q.temp_sensor_on) << `ACS_B_TEMP_SENSOR_ON;
            default: d.rdata = '0;
         endcase
      end
      d.irq = |({d.ovr, d.eos, d.eoc} & d.ien);
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         q <= '0;
         q.st <= ST_IDLE;
      end
      else
         q <= d;
   end

   assign RDATA_O = q.rdata;
   assign CHANNEL_SELECT_O = q.chan;
   assign SAMPLE_O = q.st == ST_SAMPLE;
   assign CONVERT_O = q.st == ST_CONVERT;
   assign CALIBRATE_O = q.st == ST_CAL;
   assign TEMP_SENSOR_ON_O = q.temp_sensor_on;
   assign IRQ_O = q.irq;

   // helpers for the checks
   assign ctl_wr = WR_I && ADDR_I == `ACS_OFS_CTRL;
   assign fin = q.st == ST_CONVERT && q.cnt == sar_cycles(q.res) - 8'h01 && !ctl_wr;
   assign nx_first = next_chan(q.chmask, 6'h00);
   assign nx_after = next_chan(q.chmask, {1'b0, q.chan} + 6'h01);
   assign last = !nx_after[5];

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   a_cal_blocks_conv: assert property ((q.st == ST_CAL) |=> (q.st != ST_SAMPLE))
      else $error("conversion began during calibration");
   a_cal_needs_off: assert property ($rose(q.st == ST_CAL) |-> !q.conv_on)
      else $error("calibration began with converter on");
   a_cal_factor_out: assert property (
      (q.st == ST_CAL && q.cnt == 8'(`ACS_CAL_CYC - 1))
      |=> (q.st == ST_IDLE && q.data == {9'h000, $past(q.calf_s2)}))
      else $error("calibration factor not stored");
   a_sample_two: assert property ($rose(q.st == ST_SAMPLE) && !ctl_wr
      |=> (q.st == ST_SAMPLE))
      else $error("sampling phase too short");
   a_sample_end: assert property ((q.st == ST_SAMPLE && q.cnt == 8'h01 && !ctl_wr)
      |=> (q.st == ST_CONVERT))
      else $error("sampling phase too long");
   a_conv_twelve: assert property (
      (q.st == ST_CONVERT && q.cnt == 8'h00 && q.res == 2'h0) |-> (!fin) [*8] ##1 (!fin) [*3])
      else $error("twelve-bit approximation too short");
   a_done_flag: assert property (fin |=> (q.eoc && q.data ==
      align_result($past(q.sar_s2), $past(q.res), $past(q.align))))
      else $error("result or done flag missing");
   a_overrun_set: assert property ((fin && q.eoc) |=> q.ovr)
      else $error("overrun not flagged");
   a_seq_done: assert property ((fin && last) |=> q.eos)
      else $error("sequence done not flagged");
   a_step_single: assert property ((fin && q.step) |=> (q.st == ST_IDLE))
      else $error("step mode ran past one channel");
   a_repeat_wrap: assert property (
      (fin && last && !q.step && q.repeat_mode && q.go)
      |=> (q.st == ST_SAMPLE && q.chan == $past(nx_first[4:0])))
      else $error("repeat mode did not restart");
   a_chan_range: assert property (q.chan <= `ACS_CH_VREF)
      else $error("channel out of range");

   c_calibration: cover property ($fell(q.st == ST_CAL));
   c_sequence_end: cover property (fin && last);
   c_overrun: cover property ($rose(q.ovr));
   c_hw_trigger: cover property (trig && q.go && q.st == ST_IDLE);

endmodule

// file: tb/acs_analog_model.sv
// analog core model: channel values, approximation result, calibration factor
// assumes controls come straight from the sequencer outputs
`timescale 1ns/1ns
module acs_analog_model
#(
   parameter logic [6:0] CAL = 7'h35
)
(
   // converter controls
   input wire logic [4:0] chan_i,
   input wire logic convert_i,
   input wire logic calibrate_i,
   input wire logic temp_on_i,
   // results
   output logic [11:0] sar_o,
   output logic [6:0] cal_o
);
   function automatic logic [11:0] raw_of(input logic [4:0] ch);
      raw_of = 12'hA53 ^ {ch, ch, ch[4:3]};
   endfunction
   logic ok;
   always_comb
   begin
      // sensor channel only valid while powered
      ok = convert_i && (chan_i != 5'h10 || temp_on_i);
      // released result shows the inverse, never the held value
      sar_o = ok ? raw_of(chan_i) : ~raw_of(chan_i);
      cal_o = calibrate_i ? CAL : ~CAL;
   end
endmodule

// file: tb/tb_acs_sequencer.sv
// testbench of the conversion sequencer, register port driven directly
// assumes the analog core model in acs_analog_model.sv
`timescale 1ns/1ns
`include "acs_defines.svh"
module tb_acs_sequencer;
   logic REF_CLK_I, RST_N_I, WR_I, RD_I, EXT_TRIG_I, sp;
   logic SAMPLE_O, CONVERT_O, CALIBRATE_O, TEMP_SENSOR_ON_O, IRQ_O;
   logic [11:0] ADDR_I, SAR_RESULT_I;
   logic [31:0] WDATA_I, RDATA_O, d, v;
   logic [4:0] TIMER_TRIGGER_IN_I, CHANNEL_SELECT_O;
   logic [6:0] CAL_FACTOR_I;
   logic [4:0] q[$];
   logic [4:0] stp[4] = '{5'h00, 5'h01, 5'h05, 5'h00};
   int fails, check_count, cc, n, m;
   int codes[6] = '{0, 1, 2, 3, 4, 7};
   int cyc[4] = '{12, 11, 9, 7};
   localparam logic [31:0] ON = 32'h0000_0001;
   localparam logic [31:0] GO = ON | (1 << `ACS_B_GO);
   localparam logic [31:0] FL = 32'h0000_001C;

   acs_sequencer dut_u (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
      .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
      .TIMER_TRIGGER_IN_I(TIMER_TRIGGER_IN_I), .EXT_TRIG_I(EXT_TRIG_I),
      .SAR_RESULT_I(SAR_RESULT_I), .CAL_FACTOR_I(CAL_FACTOR_I),
      .CHANNEL_SELECT_O(CHANNEL_SELECT_O), .SAMPLE_O(SAMPLE_O), .CONVERT_O(CONVERT_O),
      .CALIBRATE_O(CALIBRATE_O), .TEMP_SENSOR_ON_O(TEMP_SENSOR_ON_O), .IRQ_O(IRQ_O));
   acs_analog_model pm_u (.chan_i(CHANNEL_SELECT_O), .convert_i(CONVERT_O),
      .calibrate_i(CALIBRATE_O), .temp_on_i(TEMP_SENSOR_ON_O), .sar_o(SAR_RESULT_I),
      .cal_o(CAL_FACTOR_I));

   initial
   begin
      REF_CLK_I = 1'b0;
      forever #4 REF_CLK_I = ~REF_CLK_I;
   end

   // log channel at each sampling start, count approximation cycles
   always @(posedge REF_CLK_I)
   begin
      sp <= SAMPLE_O;
      if (SAMPLE_O && !sp)
         q.push_back(CHANNEL_SELECT_O);
      if (CONVERT_O)
         cc++;
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task wr(input logic [11:0] a, input logic [31:0] w);
      @(posedge REF_CLK_I);
      ADDR_I <= a;
      WDATA_I <= w;
      WR_I <= 1'b1;
      @(posedge REF_CLK_I);
      WR_I <= 1'b0;
   endtask

   task rd(input logic [11:0] a, output logic [31:0] r);
      @(posedge REF_CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge REF_CLK_I);
      RD_I <= 1'b0;
      #1 r = RDATA_O;
   endtask

   // drive one trigger line (5 is the pin), then count new conversions
   task hw(input int l, input logic lv, input int inc);
      int k;
      k = q.size();
      @(posedge REF_CLK_I);
      if (l == 5)
         EXT_TRIG_I <= lv;
      else
         TIMER_TRIGGER_IN_I[l] <= lv;
      repeat (40) @(posedge REF_CLK_I);
      chk(q.size(), k + inc);
   endtask

   function automatic logic [31:0] cfg(input int r, a, ts, e, rp, st);
      cfg = (r << `ACS_B_RES) | (a << `ACS_B_ALIGN) | (ts << `ACS_B_TSEL)
         | (e << `ACS_B_EDGE) | (rp << `ACS_B_REPEAT) | (st << `ACS_B_STEP);
   endfunction

   task end_of_test;
      $display("errors %0d checks %0d", fails, check_count);
      if (fails == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge REF_CLK_I);
      fails++;
      end_of_test;
   end

   initial
   begin
      RST_N_I = 1'b0;
      WR_I = 1'b0;
      RD_I = 1'b0;
      ADDR_I = 12'h000;
      WDATA_I = 32'h0000_0000;
      EXT_TRIG_I = 1'b0;
      TIMER_TRIGGER_IN_I = 5'h00;
      repeat (8) @(posedge REF_CLK_I);
      RST_N_I <= 1'b1;
      // reset value and unmapped place
      rd(`ACS_OFS_CTRL, d);
      chk(d, 32'h0000_0000);
      wr(12'h010, 32'hFFFF_FFFF);
      rd(12'h010, d);
      chk(d, 32'h0000_0000);
      // calibration with converter off
      wr(`ACS_OFS_CTRL, 1 << `ACS_B_CAL);
      rd(`ACS_OFS_CTRL, d);
      chk(d[31], 1'b1);
      chk(CALIBRATE_O, 1'b1);
      repeat (90) @(posedge REF_CLK_I);
      rd(`ACS_OFS_CTRL, d);
      chk(d, 32'h0000_0000);
      chk(q.size(), 0);
      rd(`ACS_OFS_DATA, d);
      chk(d[6:0], pm_u.CAL);
      // whole group once per software start, flags and overrun
      wr(`ACS_OFS_CTRL, ON);
      wr(`ACS_OFS_IEN, 1 << `ACS_B_EOC);
      wr(`ACS_OFS_CHSEL, 32'h0000_0023);
      wr(`ACS_OFS_CTRL, GO);
      repeat (80) @(posedge REF_CLK_I);
      chk(q.size(), 3);
      for (int k = 0; k < 3; k++)
         chk(q[k], stp[k]);
      rd(`ACS_OFS_STS, d);
      chk(d, FL);
      rd(`ACS_OFS_DATA, d);
      chk(d, {20'h0, pm_u.raw_of(5'h05)});
      chk(IRQ_O, 1'b1);
      wr(`ACS_OFS_IEN, 1 << `ACS_B_EOS);
      rd(`ACS_OFS_STS, d);
      chk(IRQ_O, 1'b1);
      wr(`ACS_OFS_IEN, 1 << `ACS_B_OVR);
      rd(`ACS_OFS_STS, d);
      chk(IRQ_O, 1'b1);
      wr(`ACS_OFS_IEN, 32'h0000_0000);
      rd(`ACS_OFS_STS, d);
      chk(IRQ_O, 1'b0);
      // one channel per start
      wr(`ACS_OFS_CFG1, cfg(0, 0, 0, 0, 0, 1));
      for (int k = 0; k < 4; k++)
      begin
         n = q.size();
         wr(`ACS_OFS_STS, FL);
         wr(`ACS_OFS_CTRL, GO);
         repeat (40) @(posedge REF_CLK_I);
         chk(q.size(), n + 1);
         chk(q[$], stp[k]);
         rd(`ACS_OFS_STS, d);
         chk(d[3], k == 2);
      end
      // resolution and alignment on the reference channel
      wr(`ACS_OFS_CHSEL, 32'h0002_0000);
      for (int r = 0; r < 4; r++)
         for (int a = 0; a < 2; a++)
         begin
            wr(`ACS_OFS_CFG1, cfg(r, a, 0, 0, 0, 0));
            cc = 0;
            wr(`ACS_OFS_CTRL, GO);
            repeat (40) @(posedge REF_CLK_I);
            chk(cc, cyc[r]);
            v = {20'h0, pm_u.raw_of(5'h11)} >> (2 * r);
            if (a == 1)
               v = v << (4 + 2 * r);
            rd(`ACS_OFS_DATA, d);
            chk(d, v);
         end
      // hardware trigger sources and edges
      wr(`ACS_OFS_CHSEL, 32'h0000_0008);
      foreach (codes[i])
      begin
         wr(`ACS_OFS_CFG1, cfg(0, 0, codes[i], 1, 0, 0));
         wr(`ACS_OFS_CTRL, GO);
         hw(i == 5 ? 5 : codes[i], 1'b1, 1);
         hw(i == 5 ? 5 : codes[i], 1'b0, 0);
      end
      wr(`ACS_OFS_CFG1, cfg(0, 0, 5, 3, 0, 0));
      hw(5, 1'b1, 0);
      hw(5, 1'b0, 0);
      wr(`ACS_OFS_CFG1, cfg(0, 0, 7, 2, 0, 0));
      hw(5, 1'b1, 0);
      hw(5, 1'b0, 1);
      wr(`ACS_OFS_CFG1, cfg(0, 0, 7, 3, 0, 0));
      hw(5, 1'b1, 1);
      hw(5, 1'b0, 1);
      wr(`ACS_OFS_CFG1, cfg(0, 0, 7, 0, 0, 0));
      hw(5, 1'b1, 0);
      wr(`ACS_OFS_CTRL, ON | (1 << `ACS_B_STOP));
      // repeated group with temperature sensor
      wr(`ACS_OFS_CCFG, 1 << `ACS_B_TEMP_SENSOR_ON);
      wr(`ACS_OFS_CHSEL, 32'h0003_0000);
      wr(`ACS_OFS_CFG1, cfg(0, 0, 0, 0, 1, 0));
      n = q.size();
      wr(`ACS_OFS_CTRL, GO);
      repeat (100) @(posedge REF_CLK_I);
      wr(`ACS_OFS_CTRL, ON | (1 << `ACS_B_STOP));
      chk(TEMP_SENSOR_ON_O, 1'b1);
      chk(q.size() >= n + 5, 1);
      chk(q[n], 5'h10);
      chk(q[n + 1], 5'h11);
      chk(q[n + 2], 5'h10);
      m = q.size();
      repeat (40) @(posedge REF_CLK_I);
      chk(q.size(), m);
      end_of_test;
   end
endmodule
